// ---- rtl/shp_consts.svh ----
// constants for the sram-like host port
`ifndef SHP_CONSTS_SVH
`define SHP_CONSTS_SVH
`define SHP_RX_WORDS 8192
`define SHP_TX_WORDS 2048
`define SHP_CFG_WORDS 64
`define SHP_RX_TOP 16'h8000
`define SHP_TX_TOP 16'hfc00
`define SHP_CFG_TOP 16'hfd00
`define SHP_CMD_IDX 6'h00
`define SHP_PHYCTL_IDX 6'h01
`define SHP_STAT_IDX 6'h02
`define SHP_CMD_IRQ_POL_BIT 6
`define SHP_CMD_WAKE_POL_BIT 0
`define SHP_PHYCTL_IND_BIT 10
`define SHP_WR_MIN_CLKS 4
`define SHP_RD_VALID_CLKS 4
`define SHP_PROM_DIV 8'h3f
`define SHP_FIFO_DEPTH 8
`endif

// ---- rtl/shp_pkg.sv ----
// types shared by the sram-like host port
package shp_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ, ST_GAP} shp_state_e;
  typedef struct packed {
    logic [31:0] data;
    logic [14:0] addr;
  } shp_wr_s;
  typedef struct packed {
    logic full_duplex;
    logic collision;
  } shp_link_s;
endpackage

// ---- rtl/shp_fifo.sv ----
// small valid/ready fifo carrying host writes to the memories
`timescale 1ns/1ps
module shp_fifo #(
  parameter int WIDTH = 47,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } shp_fifo_s;
  shp_fifo_s st_reg;
  shp_fifo_s st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // honest flags: ready drops when full so the writer stalls
  assign in_ready = (st_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[st_reg.rp];

  // pointer and count update
  always_comb
  begin
    st_next = st_reg;
    if (push)
      st_next.wp = st_reg.wp + 1'b1;
    if (pop)
      st_next.rp = st_reg.rp + 1'b1;
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
    if (push)
      mem[st_reg.wp] <= in_data;
  end
endmodule

// ---- rtl/shp_prom.sv ----
// serial prom shifter with pins reused as duplex/collision indicators
`timescale 1ns/1ps
`include "shp_consts.svh"
module shp_prom (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // control
  input wire logic start,
  input wire logic [15:0] cmd_bits,
  input wire logic indicator_mode,
  input wire shp_pkg::shp_link_s link,
  // status
  output logic busy,
  output logic [15:0] rx_bits,
  // pins
  output logic serial_prom_clk,
  output logic serial_prom_select,
  output logic serial_prom_out,
  input wire logic serial_prom_in
);
  typedef struct packed {
    logic [7:0] div;
    logic [5:0] bitn;
    logic sck;
    logic sel;
    logic dout;
    logic [15:0] sh;
    logic [15:0] rx;
  } shp_prom_s;
  shp_prom_s st_reg;
  shp_prom_s st_next;
  logic tick;

  assign tick = (st_reg.div == `SHP_PROM_DIV);
  assign busy = st_reg.sel;
  assign rx_bits = st_reg.rx;

  // data changes on falling clock, so it is stable at the rising edge
  always_comb
  begin
    st_next = st_reg;
    st_next.div = tick ? 8'h00 : st_reg.div + 8'h01;
    if (!st_reg.sel && start)
    begin
      st_next.sel = 1'b1;
      st_next.sh = cmd_bits;
      st_next.bitn = 6'h10;
      st_next.dout = cmd_bits[15];
      st_next.div = 8'h00;
    end
    else if (st_reg.sel && tick)
    begin
      st_next.sck = !st_reg.sck;
      if (!st_reg.sck)
        st_next.rx = {st_reg.rx[14:0], serial_prom_in};
      else if (st_reg.bitn == 6'h01)
      begin
        st_next.sel = 1'b0;
        st_next.dout = 1'b0;
      end
      else
      begin
        st_next.bitn = st_reg.bitn - 6'h01;
        st_next.sh = {st_reg.sh[14:0], 1'b0};
        st_next.dout = st_reg.sh[14];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // pin mux between prom and indicators
  assign serial_prom_clk = st_reg.sck;
  assign serial_prom_select = indicator_mode ? link.full_duplex : st_reg.sel;
  assign serial_prom_out = indicator_mode ? link.collision : st_reg.dout;

  a_prom_data_stable: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_reg.sel && !st_reg.sck && st_next.sck) |=> $stable(st_reg.dout))
    else $error("prom data moved at rising clock");
endmodule

// ---- rtl/shp_host_port.sv ----
// sram-like host port: strobe decode, buffers, config space, pins
// Summary of operation
// - irq output polarity follows command register bit 6.
// - wake output polarity follows command register bit 0.
// - upper data pull-downs off in 32-bit mode, on otherwise.
// - 64K byte window in 32-bit mode, at least 8K plus 8 in 16-bit.
// - separate 32K receive and 8K transmit packet memories.
// - 256 byte configuration space on the same port.
// - port works with synchronous or free host reference clock.
// - indicator mode drives prom select as full-duplex flag.
// - indicator mode drives prom data out as collision flag.
// - prom data valid while selected, sampled on rising clock.
// - read held five clocks; data valid after four.
// - link led strap at reset: high 16-bit, low 32-bit.
// - speed led strap at reset: high swaps bytes.
`timescale 1ns/1ps
`include "shp_consts.svh"
module shp_host_port (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // host strobes and buses
  input wire logic select_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [15:1] host_addr_bus,
  input wire logic [31:0] host_data_in,
  output logic [31:0] host_data_out,
  output logic [31:0] host_data_oe,
  output logic [31:16] upper_pulldown_en,
  // straps
  input wire logic link_led_strap,
  input wire logic speed_led_strap,
  // network side state
  input wire logic irq_event,
  input wire logic wake_event,
  input wire shp_pkg::shp_link_s link,
  input wire logic rx_wr_en,
  input wire logic [12:0] rx_wr_addr,
  input wire logic [31:0] rx_wr_data,
  input wire logic [10:0] tx_rd_addr,
  output logic [31:0] tx_rd_data,
  // interrupt and wake pins with enables
  output logic host_irq_out,
  output logic host_irq_oe,
  output logic wake_out,
  output logic wake_oe,
  // serial prom
  output logic serial_prom_clk,
  output logic serial_prom_select,
  output logic serial_prom_out,
  input wire logic serial_prom_in,
  // mode status
  output logic mode_16bit,
  output logic big_endian
);
  typedef struct packed {
    shp_pkg::shp_state_e state;
    logic [2:0] cnt;
    logic [31:0] rdata;
    logic rvalid;
    logic [15:0] cmd;
    logic [15:0] phyctl;
    logic strap_done;
    logic m16;
    logic swap;
    logic wpend;
  } shp_top_s;
  shp_top_s st_reg;
  shp_top_s st_next;

  logic [31:0] rx_mem [`SHP_RX_WORDS];
  logic [31:0] tx_mem [`SHP_TX_WORDS];
  logic [31:0] cfg_mem [`SHP_CFG_WORDS];
  logic [15:0] byte_addr;
  logic [31:0] din;
  logic [31:0] rx_q;
  logic [31:0] tx_q;
  logic [31:0] cfg_q;
  logic sel;
  logic wr_act;
  logic rd_act;
  shp_pkg::shp_wr_s fifo_in;
  shp_pkg::shp_wr_s fifo_out;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic prom_busy;
  logic [15:0] prom_rx;

  // region decode, used for both reads and writes
  function automatic logic [1:0] region(input logic [15:0] a);
    if (a < `SHP_RX_TOP)
      region = 2'h0;
    else if (a < `SHP_TX_TOP)
      region = 2'h1;
    else if (a < `SHP_CFG_TOP)
      region = 2'h2;
    else
      region = 2'h3;
  endfunction

  // byte swap for big-endian straps
  function automatic logic [31:0] order(input logic [31:0] d, input logic sw, input logic h);
    if (!sw)
      order = d;
    else if (h)
      order = {16'h0000, d[7:0], d[15:8]};
    else
      order = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // strobe qualification; lines 1..15 only, bit 0 forced low
  assign byte_addr = {host_addr_bus, 1'b0};
  assign sel = !select_n;
  assign wr_act = sel && !write_strobe_n;
  assign rd_act = sel && !read_strobe_n;
  // in 16-bit mode the upper lanes are ignored and read as zero
  assign din = order(st_reg.m16 ? {16'h0000, host_data_in[15:0]} : host_data_in,
                     st_reg.swap, st_reg.m16);

  ////////////////////////////////////////////////////////////////////////
  // access sequencer; counts on sys_clk, so any host clock relation works
  always_comb
  begin
    st_next = st_reg;
    fifo_in_valid = 1'b0;
    fifo_in.addr = byte_addr[15:1];
    fifo_in.data = din;
    if (!st_reg.strap_done)
    begin
      st_next.strap_done = 1'b1;
      st_next.m16 = link_led_strap;
      st_next.swap = speed_led_strap;
    end
    if (st_reg.wpend && !prom_busy)
      st_next.wpend = 1'b0;
    case (st_reg.state)
      shp_pkg::ST_IDLE:
      begin
        st_next.cnt = 3'h1;
        st_next.rvalid = 1'b0;
        if (wr_act)
          st_next.state = shp_pkg::ST_WRITE;
        else if (rd_act)
          st_next.state = shp_pkg::ST_READ;
      end
      shp_pkg::ST_WRITE:
      begin
        if (!wr_act)
          st_next.state = shp_pkg::ST_IDLE;
        else if (st_reg.cnt != 3'(`SHP_WR_MIN_CLKS - 1))
          st_next.cnt = st_reg.cnt + 3'h1;
        else if (fifo_in_ready)
        begin
          fifo_in_valid = 1'b1;
          st_next.state = shp_pkg::ST_GAP;
        end
      end
      shp_pkg::ST_READ:
      begin
        if (!rd_act)
          st_next.state = shp_pkg::ST_IDLE;
        else if (st_reg.cnt != 3'(`SHP_RD_VALID_CLKS - 1))
          st_next.cnt = st_reg.cnt + 3'h1;
        else
        begin
          st_next.rvalid = 1'b1;
          case (region(byte_addr))
            2'h0: st_next.rdata = order(rx_q, st_reg.swap, st_reg.m16);
            2'h1: st_next.rdata = order(tx_q, st_reg.swap, st_reg.m16);
            2'h2: st_next.rdata = order(cfg_q, st_reg.swap, st_reg.m16);
            default: st_next.rdata = 32'h00000000;
          endcase
          st_next.state = shp_pkg::ST_GAP;
        end
      end
      shp_pkg::ST_GAP:
      begin
        // wait for strobe release before the next access
        if (!wr_act && !rd_act)
        begin
          st_next.state = shp_pkg::ST_IDLE;
          st_next.rvalid = 1'b0;
        end
      end
      default: st_next.state = shp_pkg::ST_IDLE;
    endcase
    // command and phy control writes land here when drained
    if (fifo_out_valid && region({fifo_out.addr, 1'b0}) == 2'h2)
    begin
      if (fifo_out.addr[6:1] == `SHP_CMD_IDX)
        st_next.cmd = fifo_out.data[15:0];
      if (fifo_out.addr[6:1] == `SHP_PHYCTL_IDX)
      begin
        st_next.phyctl = fifo_out.data[15:0];
        st_next.wpend = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      st_reg <= '0;
      st_reg.state <= shp_pkg::ST_IDLE;
    end
    else
      st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // write fifo: full fifo holds the sequencer, which waits with the strobe
  shp_fifo #(.WIDTH(47), .DEPTH(`SHP_FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out)
  );

  // synchronous packet memories
  always_ff @(posedge sys_clk)
  begin
    if (rx_wr_en)
      rx_mem[rx_wr_addr] <= rx_wr_data;
    if (fifo_out_valid && region({fifo_out.addr, 1'b0}) == 2'h1)
      tx_mem[fifo_out.addr[11:1]] <= fifo_out.data;
    if (fifo_out_valid && region({fifo_out.addr, 1'b0}) == 2'h2)
      cfg_mem[fifo_out.addr[6:1]] <= fifo_out.data;
    rx_q <= rx_mem[byte_addr[14:2]];
    tx_q <= tx_mem[byte_addr[12:2]];
    cfg_q <= (byte_addr[7:2] == `SHP_STAT_IDX) ? {16'h0000, prom_rx} : cfg_mem[byte_addr[7:2]];
    tx_rd_data <= tx_mem[tx_rd_addr];
  end

  ////////////////////////////////////////////////////////////////////////
  // prom engine; a phy control write kicks a transfer when not indicating
  shp_prom u_prom (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(st_reg.wpend && !st_reg.phyctl[`SHP_PHYCTL_IND_BIT]),
    .cmd_bits(st_reg.cmd),
    .indicator_mode(st_reg.phyctl[`SHP_PHYCTL_IND_BIT]),
    .link(link),
    .busy(prom_busy),
    .rx_bits(prom_rx),
    .serial_prom_clk(serial_prom_clk),
    .serial_prom_select(serial_prom_select),
    .serial_prom_out(serial_prom_out),
    .serial_prom_in(serial_prom_in)
  );

  ////////////////////////////////////////////////////////////////////////
  // host data drive and pin polarities
  assign host_data_out = st_reg.rdata;
  assign host_data_oe = (st_reg.rvalid && rd_act) ?
    (st_reg.m16 ? 32'h0000ffff : 32'hffffffff) : 32'h00000000;
  assign upper_pulldown_en = st_reg.m16 ? 16'hffff : 16'h0000;
  assign host_irq_out = irq_event ~^ st_reg.cmd[`SHP_CMD_IRQ_POL_BIT];
  assign host_irq_oe = 1'b1;
  assign wake_out = wake_event ~^ st_reg.cmd[`SHP_CMD_WAKE_POL_BIT];
  assign wake_oe = 1'b1;
  assign mode_16bit = st_reg.m16;
  assign big_endian = st_reg.swap;

  a_read_valid_time: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_reg.state == shp_pkg::ST_IDLE && rd_act) ##1 rd_act [*3] |=> st_reg.rvalid)
    else $error("read data not valid after four clocks");
  a_irq_polarity: assert property (@(posedge sys_clk) disable iff (!reset_n)
    host_irq_out == (irq_event == st_reg.cmd[6]))
    else $error("irq polarity wrong");
  a_wake_polarity: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wake_out == (wake_event == st_reg.cmd[0]))
    else $error("wake polarity wrong");
  a_pulldown_mode: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (upper_pulldown_en == 16'h0000) == !mode_16bit)
    else $error("pull-down state wrong");
  a_ind_duplex: assert property (@(posedge sys_clk) disable iff (!reset_n)
    st_reg.phyctl[10] |-> serial_prom_select == link.full_duplex)
    else $error("duplex indicator wrong");
  a_ind_collision: assert property (@(posedge sys_clk) disable iff (!reset_n)
    st_reg.phyctl[10] |-> serial_prom_out == link.collision)
    else $error("collision indicator wrong");
  a_strap_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $past(st_reg.strap_done) |-> $stable(mode_16bit) && $stable(big_endian))
    else $error("strap changed after capture");
  a_write_min_len: assert property (@(posedge sys_clk) disable iff (!reset_n)
    fifo_in_valid |-> $past(wr_act, 3) && $past(wr_act, 2) && $past(wr_act))
    else $error("write taken before four clocks");
endmodule

// ---- test/shp_prom_model.sv ----
// behavioural serial prom answering on the prom pins
`timescale 1ns/1ps
module shp_prom_model (
  // prom pins
  input wire logic serial_prom_clk,
  input wire logic serial_prom_select,
  input wire logic serial_prom_out,
  output logic serial_prom_in,
  // observation
  output int bit_count
);
  logic [15:0] reply_reg;
  logic drive_bit;

  // the data-in pin has a pull-down, so an idle prom lets it fall to 0
  assign serial_prom_in = serial_prom_select ? drive_bit : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // sample only on rising prom clock while selected
  initial
  begin
    bit_count = 0;
    reply_reg = 16'ha5c3;
    drive_bit = 1'b0;
  end
  always @(posedge serial_prom_clk)
  begin
    if (serial_prom_select)
    begin
      bit_count = bit_count + 1;
      drive_bit = reply_reg[15] ^ serial_prom_out;
      reply_reg = {reply_reg[14:0], reply_reg[15]};
    end
  end
endmodule

// ---- test/shp_host_port_test.sv ----
// self-checking bench of the host port driven through its strobes
`timescale 1ns/1ps
`define EXPECT(what, exp, got) \
  checks_done++; \
  if ((got) !== (exp)) \
  begin \
    failures++; \
    $display("unexpected %s expected %h seen %h", what, exp, got); \
  end
module shp_host_port_test;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic select_n = 1'b1;
  logic write_strobe_n = 1'b1;
  logic read_strobe_n = 1'b1;
  logic [15:1] host_addr_bus = 15'h0000;
  logic [31:0] host_data_in = 32'h0000_0000;
  logic [31:0] host_data_out, host_data_oe, tx_rd_data, rd_val, rd_oe;
  logic [31:16] upper_pulldown_en;
  logic link_led_strap = 1'b0;
  logic speed_led_strap = 1'b0;
  logic irq_event = 1'b1;
  logic wake_event = 1'b0;
  shp_pkg::shp_link_s link = '0;
  logic rx_wr_en = 1'b0;
  logic [12:0] rx_wr_addr = 13'h0000;
  logic [31:0] rx_wr_data = 32'h0000_0000;
  logic [10:0] tx_rd_addr = 11'h000;
  logic host_irq_out, host_irq_oe, wake_out, wake_oe;
  logic serial_prom_clk, serial_prom_select, serial_prom_out, serial_prom_in;
  logic mode_16bit, big_endian;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int bit_count;

  shp_host_port u_shp_host_port (.sys_clk(sys_clk), .reset_n(reset_n), .select_n(select_n),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .host_addr_bus(host_addr_bus), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .upper_pulldown_en(upper_pulldown_en), .link_led_strap(link_led_strap),
    .speed_led_strap(speed_led_strap), .irq_event(irq_event), .wake_event(wake_event),
    .link(link), .rx_wr_en(rx_wr_en), .rx_wr_addr(rx_wr_addr), .rx_wr_data(rx_wr_data),
    .tx_rd_addr(tx_rd_addr), .tx_rd_data(tx_rd_data), .host_irq_out(host_irq_out),
    .host_irq_oe(host_irq_oe), .wake_out(wake_out), .wake_oe(wake_oe),
    .serial_prom_clk(serial_prom_clk), .serial_prom_select(serial_prom_select),
    .serial_prom_out(serial_prom_out), .serial_prom_in(serial_prom_in),
    .mode_16bit(mode_16bit), .big_endian(big_endian));

  shp_prom_model u_shp_prom_model (.serial_prom_clk(serial_prom_clk),
    .serial_prom_select(serial_prom_select), .serial_prom_out(serial_prom_out),
    .serial_prom_in(serial_prom_in), .bit_count(bit_count));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard; the whole run needs well under 20000 cycles
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic do_reset(input logic link_strap, input logic speed_strap);
    reset_n = 1'b0;
    link_led_strap = link_strap;
    speed_led_strap = speed_strap;
    tick(16);
    reset_n = 1'b1;
    tick(2);
  endtask

  // strobes held for hold edges, then a released gap before the next access
  task automatic host_write(input logic [15:0] addr, input logic [31:0] data, input int hold);
    select_n = 1'b0;
    write_strobe_n = 1'b0;
    host_addr_bus = addr[15:1];
    host_data_in = data;
    tick(hold);
    select_n = 1'b1;
    write_strobe_n = 1'b1;
    tick(3);
  endtask

  // read held at least five edges, data taken at the edge that shows it driven
  task automatic host_read(input logic [15:0] addr, output logic [31:0] data);
    int n;
    select_n = 1'b0;
    read_strobe_n = 1'b0;
    host_addr_bus = addr[15:1];
    repeat (4) @(posedge sys_clk);
    n = 0;
    @(posedge sys_clk);
    while (host_data_oe[0] !== 1'b1 && n < 8)
    begin
      n++;
      @(posedge sys_clk);
    end
    data = host_data_out;
    rd_oe = host_data_oe;
    `EXPECT("read wait", 0, n)
    #1;
    select_n = 1'b1;
    read_strobe_n = 1'b1;
    tick(2);
  endtask

  task automatic check_tx(input logic [10:0] idx, input logic [31:0] exp);
    tx_rd_addr = idx;
    tick(2);
    `EXPECT("tx word", exp, tx_rd_data)
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    int n;
    tick(1);
    do_reset(1'b0, 1'b0);
    `EXPECT("mode_16bit", 1'b0, mode_16bit)
    `EXPECT("big_endian", 1'b0, big_endian)
    `EXPECT("pulldowns", 16'h0000, upper_pulldown_en)
    `EXPECT("irq idle", 1'b0, host_irq_out)
    `EXPECT("wake idle", 1'b1, wake_out)
    // polarity bits set: outputs follow events directly
    host_write(16'hfc00, 32'h0000_0041, 4);
    `EXPECT("irq high pol", 1'b1, host_irq_out)
    `EXPECT("wake high pol", 1'b0, wake_out)
    `EXPECT("irq oe", 1'b1, host_irq_oe)
    `EXPECT("wake oe", 1'b1, wake_oe)
    host_write(16'hfc00, 32'h0000_0000, 4);
    `EXPECT("irq low pol", 1'b0, host_irq_out)
    // transmit memory: back-to-back writes, then a short write is dropped
    host_write(16'h8000, 32'h89ab_cdef, 4);
    host_write(16'h8004, 32'h2468_ace0, 4);
    host_write(16'h8004, 32'h1111_1111, 2);
    check_tx(11'h000, 32'h89ab_cdef);
    check_tx(11'h001, 32'h2468_ace0);
    host_write(16'h9ffc, 32'h0f0f_0f0f, 4);
    check_tx(11'h7ff, 32'h0f0f_0f0f);
    // receive memory filled from the network side, read by the host
    rx_wr_en = 1'b1;
    rx_wr_addr = 13'h1fff;
    rx_wr_data = 32'h1357_9bdf;
    tick(1);
    rx_wr_en = 1'b0;
    tick(1);
    host_read(16'h7ffc, rd_val);
    `EXPECT("rx read", 32'h1357_9bdf, rd_val)
    `EXPECT("read lanes", 32'hffff_ffff, rd_oe)
    host_read(16'hfe00, rd_val);
    `EXPECT("unmapped read", 32'h0000_0000, rd_val)
    // indicator mode on the prom pins
    host_write(16'hfc04, 32'h0000_0400, 4);
    link = '{full_duplex: 1'b1, collision: 1'b0};
    tick(1);
    `EXPECT("duplex pin", 1'b1, serial_prom_select)
    `EXPECT("collision pin", 1'b0, serial_prom_out)
    link = '{full_duplex: 1'b0, collision: 1'b1};
    tick(1);
    `EXPECT("duplex pin", 1'b0, serial_prom_select)
    `EXPECT("collision pin", 1'b1, serial_prom_out)
    // indicator off starts a prom shift; the prom must see clocked bits
    host_write(16'hfc04, 32'h0000_0000, 4);
    n = 0;
    while (serial_prom_select !== 1'b1 && n < 500)
    begin
      n++;
      tick(1);
    end
    `EXPECT("prom select", 1'b1, serial_prom_select)
    n = 0;
    while (serial_prom_select !== 1'b0 && n < 8000)
    begin
      n++;
      tick(1);
    end
    `EXPECT("prom bits", 16, bit_count)
    `EXPECT("prom clk idle", 1'b0, serial_prom_clk)
    // model replies with its rotating pattern; the first captured bit is the idle 0
    host_read(16'hfc08, rd_val);
    `EXPECT("prom reply", 32'h0000_52e1, rd_val)
    // second reset with both straps high: 16-bit and swapped
    do_reset(1'b1, 1'b1);
    `EXPECT("mode_16bit", 1'b1, mode_16bit)
    `EXPECT("big_endian", 1'b1, big_endian)
    `EXPECT("pulldowns", 16'hffff, upper_pulldown_en)
    host_write(16'h8000, 32'h0000_1234, 4);
    tx_rd_addr = 11'h000;
    tick(2);
    `EXPECT("swapped half", 16'h3412, tx_rd_data[15:0])
    host_read(16'h8000, rd_val);
    `EXPECT("swapped read", 16'h1234, rd_val[15:0])
    `EXPECT("read lanes", 32'h0000_ffff, rd_oe)
    // third reset: 32-bit bus with full word byte reversal
    do_reset(1'b0, 1'b1);
    host_write(16'h8000, 32'h1234_5678, 4);
    check_tx(11'h000, 32'h7856_3412);
    tally_and_finish();
  end
endmodule
